// file: pkg/power_reset_pkg.sv
package power_reset_pkg;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_POWER_DOWN = 2'b10,
    MODE_TOTAL_POWER_DOWN = 2'b11
  } power_mode_t;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [4:0] ADDR_POWER_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_CLOCK_DIVIDER = 5'h04;
  localparam logic [4:0] ADDR_RESET_SOURCE = 5'h08;
  localparam logic [4:0] ADDR_USER_CONFIG = 5'h0C;
  localparam logic [4:0] ADDR_TIMER_CONTROL = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;

  ////////////////////////////////////////////////////////////////////////////
  // power control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BROWNOUT_EN = 2;
  localparam int CTRL_BROWNOUT_IRQ = 3;
  localparam int CTRL_COMPARATOR_EN = 4;
  localparam int CTRL_RC_SELECT = 5;
  localparam int CTRL_SOFT_RESET = 7;
  localparam logic BROWNOUT_EN_RESET = 1'b1;
  localparam logic COMPARATOR_EN_RESET = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // reset source flags
  localparam int FLAG_COUNT = 6;
  localparam int FLAG_PIN = 0;
  localparam int FLAG_POWER_ON = 1;
  localparam int FLAG_BROWNOUT = 2;
  localparam int FLAG_WATCHDOG = 3;
  localparam int FLAG_SOFTWARE = 4;
  localparam int FLAG_UART_BREAK = 5;
  localparam logic [5:0] FLAGS_POWER_ON_VALUE = 6'h06;

  ////////////////////////////////////////////////////////////////////////////
  // config, timer and status fields
  localparam int CFG_RESET_PIN_ENABLE = 0;
  localparam logic RESET_PIN_ENABLE_RESET = 1'b0;
  localparam int TIMER_ENABLE_BIT = 0;
  localparam int STAT_PIN_LEVEL = 2;
  localparam int STAT_POWER_UP = 3;
  localparam int STAT_BROWNOUT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // clock division and timing
  localparam int DIVIDER_WIDTH = 8;
  localparam int DIV_COUNT_WIDTH = 9;
  localparam logic [8:0] DIV_ONE = 9'h001;
  localparam int CLK_PERIOD_NS = 40;
  localparam int POWER_UP_TIME_NS = 2000;
  localparam logic [5:0] POWER_UP_CYCLES =
    6'((POWER_UP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// file: rtl/power_mode_and_reset_control.sv
//Contract
// - software selects idle, power-down or total power-down through the control register
// - idle halts cpu, peripherals run; enabled interrupt or reset ends idle
// - cpu clock is oscillator clock divided by programmable value, up to 510
// - divider may change anytime; new ratio applies to the running period, a smaller one ending it at once
// - power-down stops oscillator, so cpu clock stops until wake
// - power-down ends on any reset or wake-capable interrupt
// - brownout, watchdog, comparators and system timer keep running in power-down
// - rc oscillator off in power-down unless selected and system timer enabled
// - total power-down also disables brownout detection and comparators
// - reset-pin-enable set makes pin active-low reset, else digital input
// - during power-up the pin is always a reset input
// - only power-up overrides pin function; other resets keep it
// - six reset sources: pin, power-on, brownout, watchdog, software, uart break
// - each reset source owns a readable flag in the reset source register
// - writing 0 clears a flag; several flags may be set together
// - power-on sets power-on and brownout flags, clears all others
// - other resets set own flag, keep uncleared earlier flags
// - system timer control resets only on power-on reset
// - power-on flag stays set until software clears it
// - brownout resets by default, optionally raises an interrupt instead
// - keypad pattern interrupt wakes from idle or power-down
module power_mode_and_reset_control
  import power_reset_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic [4:0] ADDRESS_IN,
  input wire logic READ_IN,
  input wire logic WRITE_IN,
  input wire logic [3:0] BYTEENABLE_IN,
  input wire logic [31:0] WRITEDATA_IN,
  output logic [31:0] READDATA_OUT,
  output logic WAITREQUEST_OUT,
  input wire logic SHARED_RESET_INPUT_PIN_IN,
  input wire logic BROWNOUT_DETECT_IN,
  input wire logic WATCHDOG_RESET_IN,
  input wire logic UART_BREAK_RESET_IN,
  input wire logic IRQ_PENDING_IN,
  input wire logic WAKEUP_IRQ_IN,
  input wire logic KEYPAD_IRQ_IN,
  output logic SYSTEM_RESET_OUT,
  output logic CPU_CLOCK_EN_OUT,
  output logic PERIPH_CLOCK_EN_OUT,
  output logic CPU_HALT_OUT,
  output logic OSCILLATOR_ENABLE_OUT,
  output logic RC_OSCILLATOR_ENABLE_OUT,
  output logic BROWNOUT_DETECT_ENABLE_OUT,
  output logic BROWNOUT_IRQ_OUT,
  output logic COMPARATOR_ENABLE_OUT,
  output logic WATCHDOG_RUN_OUT,
  output logic SYSTEM_TIMER_RUN_OUT,
  output logic PIN_DIGITAL_OUT
);

  typedef struct packed {
    logic [1:0] pin_sync;
    logic [1:0] brown_sync;
    logic power_up;
    logic [5:0] power_up_count;
    power_mode_t mode;
    logic bo_en;
    logic bo_irq;
    logic comp_en;
    logic rc_sel;
    logic [7:0] divider;
    logic [8:0] div_count;
    logic soft_req;
    logic reset_pin_enable;
    logic timer_en;
    logic [5:0] flags;
    logic [5:0] pending;
    logic sys_reset;
    logic wait_n;
    logic [31:0] rdata;
    logic cpu_en;
    logic periph_en;
    logic cpu_halt;
    logic osc_en;
    logic rc_en;
    logic bo_det_en;
    logic bo_irq_out;
    logic comp_out_en;
    logic wdt_run;
    logic timer_run;
    logic pin_digital;
  } state_t;

  localparam state_t RESET_STATE = '{
    pin_sync: 2'h3,
    brown_sync: 2'h0,
    power_up: 1'b1,
    power_up_count: 6'h00,
    mode: MODE_RUN,
    bo_en: BROWNOUT_EN_RESET,
    bo_irq: 1'b0,
    comp_en: COMPARATOR_EN_RESET,
    rc_sel: 1'b0,
    divider: 8'h00,
    div_count: 9'h000,
    soft_req: 1'b0,
    reset_pin_enable: RESET_PIN_ENABLE_RESET,
    timer_en: 1'b0,
    flags: FLAGS_POWER_ON_VALUE,
    pending: 6'h00,
    sys_reset: 1'b1,
    wait_n: 1'b1,
    rdata: 32'h00000000,
    cpu_en: 1'b0,
    periph_en: 1'b0,
    cpu_halt: 1'b0,
    osc_en: 1'b1,
    rc_en: 1'b0,
    bo_det_en: 1'b0,
    bo_irq_out: 1'b0,
    comp_out_en: 1'b0,
    wdt_run: 1'b0,
    timer_run: 1'b0,
    pin_digital: 1'b0
  };

  state_t state_reg;
  state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] offset);
    hit = (addr == offset);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic pin_level;
  logic brown_level;
  logic pin_reset;
  logic bo_active;
  logic [5:0] sources;
  logic any_reset;
  logic [5:0] capture;
  logic [5:0] keep_mask;
  logic do_write;
  logic [7:0] wbyte;
  logic [8:0] limit;
  logic tick;
  logic osc_run;
  logic tpd;

  always_comb begin
    state_next = state_reg;
    pin_level = state_reg.pin_sync[1];
    brown_level = state_reg.brown_sync[1];
    tpd = (state_reg.mode == MODE_TOTAL_POWER_DOWN);
    osc_run = (state_reg.mode == MODE_RUN) || (state_reg.mode == MODE_IDLE);
    do_write = WRITE_IN && !state_reg.wait_n && BYTEENABLE_IN[0];
    wbyte = WRITEDATA_IN[7:0];

    // two-stage synchronisers for the pin and the brownout comparator
    state_next.pin_sync = {state_reg.pin_sync[0], SHARED_RESET_INPUT_PIN_IN};
    state_next.brown_sync = {state_reg.brown_sync[0], BROWNOUT_DETECT_IN};

    // power-up forces the pin to act as reset; afterwards the bit decides
    pin_reset = (state_reg.power_up || state_reg.reset_pin_enable) && !pin_level;
    // a held-low pin keeps the power-up counter at zero
    if (state_reg.power_up) begin
      if (!pin_level) begin
        state_next.power_up_count = 6'h00;
      end else if (state_reg.power_up_count == POWER_UP_CYCLES - 6'h01) begin
        state_next.power_up = 1'b0;
      end else begin
        state_next.power_up_count = state_reg.power_up_count + 6'h01;
      end
    end

    // brownout is ignored in total power-down, so no reset either
    bo_active = brown_level && state_reg.bo_en && !tpd;
    sources = 6'h00;
    sources[FLAG_PIN] = pin_reset && !state_reg.power_up;
    sources[FLAG_BROWNOUT] = bo_active && !state_reg.bo_irq;
    sources[FLAG_WATCHDOG] = WATCHDOG_RESET_IN;
    sources[FLAG_SOFTWARE] = state_reg.soft_req;
    sources[FLAG_UART_BREAK] = UART_BREAK_RESET_IN;
    any_reset = (|sources) || pin_reset || state_reg.power_up;
    state_next.sys_reset = any_reset;
    state_next.pending = any_reset ? (state_reg.pending | sources) : 6'h00;
    capture = (state_reg.sys_reset && !any_reset) ? state_reg.pending : 6'h00;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, then the access completes
    state_next.soft_req = 1'b0;
    keep_mask = 6'h3F;
    if ((READ_IN || WRITE_IN) && state_reg.wait_n) begin
      state_next.wait_n = 1'b0;
      state_next.rdata = 32'h00000000;
      if (hit(ADDRESS_IN, ADDR_POWER_CONTROL)) begin
        state_next.rdata[1:0] = state_reg.mode;
        state_next.rdata[CTRL_BROWNOUT_EN] = state_reg.bo_en;
        state_next.rdata[CTRL_BROWNOUT_IRQ] = state_reg.bo_irq;
        state_next.rdata[CTRL_COMPARATOR_EN] = state_reg.comp_en;
        state_next.rdata[CTRL_RC_SELECT] = state_reg.rc_sel;
      end else if (hit(ADDRESS_IN, ADDR_CLOCK_DIVIDER)) begin
        state_next.rdata[7:0] = state_reg.divider;
      end else if (hit(ADDRESS_IN, ADDR_RESET_SOURCE)) begin
        state_next.rdata[5:0] = state_reg.flags;
      end else if (hit(ADDRESS_IN, ADDR_USER_CONFIG)) begin
        state_next.rdata[CFG_RESET_PIN_ENABLE] = state_reg.reset_pin_enable;
      end else if (hit(ADDRESS_IN, ADDR_TIMER_CONTROL)) begin
        state_next.rdata[TIMER_ENABLE_BIT] = state_reg.timer_en;
      end else if (hit(ADDRESS_IN, ADDR_STATUS)) begin
        state_next.rdata[1:0] = state_reg.mode;
        state_next.rdata[STAT_PIN_LEVEL] = pin_level;
        state_next.rdata[STAT_POWER_UP] = state_reg.power_up;
        state_next.rdata[STAT_BROWNOUT] = brown_level;
      end
    end else if (!state_reg.wait_n) begin
      state_next.wait_n = 1'b1;
      if (do_write) begin
        if (hit(ADDRESS_IN, ADDR_POWER_CONTROL)) begin
          state_next.mode = power_mode_t'(wbyte[1:0]);
          state_next.bo_en = wbyte[CTRL_BROWNOUT_EN];
          state_next.bo_irq = wbyte[CTRL_BROWNOUT_IRQ];
          state_next.comp_en = wbyte[CTRL_COMPARATOR_EN];
          state_next.rc_sel = wbyte[CTRL_RC_SELECT];
          state_next.soft_req = wbyte[CTRL_SOFT_RESET];
        end else if (hit(ADDRESS_IN, ADDR_CLOCK_DIVIDER)) begin
          state_next.divider = wbyte;
        end else if (hit(ADDRESS_IN, ADDR_RESET_SOURCE)) begin
          keep_mask = wbyte[5:0];
        end else if (hit(ADDRESS_IN, ADDR_USER_CONFIG)) begin
          state_next.reset_pin_enable = wbyte[CFG_RESET_PIN_ENABLE];
        end else if (hit(ADDRESS_IN, ADDR_TIMER_CONTROL)) begin
          state_next.timer_en = wbyte[TIMER_ENABLE_BIT];
        end
      end
    end

    // a capture wins over a software clear in the same cycle
    state_next.flags = (state_reg.flags & keep_mask) | capture;

    ////////////////////////////////////////////////////////////////////////////
    // wake-up: idle on any enabled interrupt, power-down only on wake sources
    if (state_reg.mode == MODE_IDLE) begin
      if (IRQ_PENDING_IN || KEYPAD_IRQ_IN) begin
        state_next.mode = MODE_RUN;
      end
    end else if (state_reg.mode != MODE_RUN) begin
      if (WAKEUP_IRQ_IN || KEYPAD_IRQ_IN) begin
        state_next.mode = MODE_RUN;
      end
    end
    // timer enable survives here on purpose: of the resets only RESET_IN clears it, besides a software write
    if (any_reset) begin
      state_next.mode = MODE_RUN;
      state_next.divider = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // divider: limit is read every cycle, so a rewrite to a smaller value ends the current period at once
    limit = (state_reg.divider == 8'h00) ? DIV_ONE : {state_reg.divider, 1'b0};
    tick = (state_reg.div_count >= limit - DIV_ONE);
    if (!osc_run || tick) begin
      state_next.div_count = 9'h000;
    end else begin
      state_next.div_count = state_reg.div_count + DIV_ONE;
    end
    state_next.cpu_en = tick && (state_reg.mode == MODE_RUN);
    state_next.periph_en = tick && osc_run;
    state_next.cpu_halt = (state_reg.mode != MODE_RUN);
    state_next.osc_en = osc_run;

    // rc runs when selected; in power-down only if it also clocks the timer
    state_next.rc_en = state_reg.rc_sel && (osc_run || state_reg.timer_en);
    state_next.bo_det_en = state_reg.bo_en && !tpd;
    state_next.bo_irq_out = bo_active && state_reg.bo_irq;
    state_next.comp_out_en = state_reg.comp_en && !tpd;
    state_next.wdt_run = 1'b1;
    state_next.timer_run = state_reg.timer_en;
    // digital value reads high while the pin serves as reset
    state_next.pin_digital = (state_reg.power_up || state_reg.reset_pin_enable) ? 1'b1 : pin_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on reset restores everything, flags to power-on and brownout
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign READDATA_OUT = state_reg.rdata;
  assign WAITREQUEST_OUT = state_reg.wait_n;
  assign SYSTEM_RESET_OUT = state_reg.sys_reset;
  assign CPU_CLOCK_EN_OUT = state_reg.cpu_en;
  assign PERIPH_CLOCK_EN_OUT = state_reg.periph_en;
  assign CPU_HALT_OUT = state_reg.cpu_halt;
  assign OSCILLATOR_ENABLE_OUT = state_reg.osc_en;
  assign RC_OSCILLATOR_ENABLE_OUT = state_reg.rc_en;
  assign BROWNOUT_DETECT_ENABLE_OUT = state_reg.bo_det_en;
  assign BROWNOUT_IRQ_OUT = state_reg.bo_irq_out;
  assign COMPARATOR_ENABLE_OUT = state_reg.comp_out_en;
  assign WATCHDOG_RUN_OUT = state_reg.wdt_run;
  assign SYSTEM_TIMER_RUN_OUT = state_reg.timer_run;
  assign PIN_DIGITAL_OUT = state_reg.pin_digital;

endmodule

// file: tb/power_mode_and_reset_control_properties.sv
module power_reset_props
  import power_reset_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic [4:0] ADDRESS_IN,
  input wire logic READ_IN,
  input wire logic WRITE_IN,
  input wire logic [3:0] BYTEENABLE_IN,
  input wire logic [31:0] WRITEDATA_IN,
  input wire logic WAITREQUEST_OUT,
  input wire logic WATCHDOG_RESET_IN,
  input wire logic IRQ_PENDING_IN,
  input wire logic WAKEUP_IRQ_IN,
  input wire logic KEYPAD_IRQ_IN,
  input wire logic SYSTEM_RESET_OUT,
  input wire logic CPU_CLOCK_EN_OUT,
  input wire logic PERIPH_CLOCK_EN_OUT,
  input wire logic CPU_HALT_OUT,
  input wire logic OSCILLATOR_ENABLE_OUT,
  input wire logic RC_OSCILLATOR_ENABLE_OUT,
  input wire logic WATCHDOG_RUN_OUT,
  input wire logic SYSTEM_TIMER_RUN_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  ////////////////////////////////////////////////////////////////////////////
  sequence taken_s;
    (READ_IN || WRITE_IN) && WAITREQUEST_OUT;
  endsequence
  sequence soft_wr_s;
    WRITE_IN && !WAITREQUEST_OUT && ADDRESS_IN == ADDR_POWER_CONTROL && BYTEENABLE_IN[0]
      && WRITEDATA_IN[CTRL_SOFT_RESET];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  bus_wait_a: assert property (taken_s |=> !WAITREQUEST_OUT ##1 WAITREQUEST_OUT)
    else $error("bus answer not one wait cycle");
  soft_reset_a: assert property (soft_wr_s |-> ##[1:3] SYSTEM_RESET_OUT)
    else $error("software reset missing");
  source_hold_a: assert property (WATCHDOG_RESET_IN [*2] |-> SYSTEM_RESET_OUT)
    else $error("reset not held while source active");
  halt_gate_a: assert property (CPU_HALT_OUT |-> !CPU_CLOCK_EN_OUT)
    else $error("cpu clock while halted");
  osc_stop_a: assert property (!OSCILLATOR_ENABLE_OUT |-> CPU_HALT_OUT && !PERIPH_CLOCK_EN_OUT)
    else $error("clocks run with oscillator off");
  idle_wake_a: assert property (CPU_HALT_OUT && OSCILLATOR_ENABLE_OUT && IRQ_PENDING_IN
    |-> ##[1:3] !CPU_HALT_OUT)
    else $error("interrupt did not end idle");
  pd_wake_a: assert property (!OSCILLATOR_ENABLE_OUT && WAKEUP_IRQ_IN
    |-> ##[1:3] OSCILLATOR_ENABLE_OUT)
    else $error("wake interrupt did not end power-down");
  key_wake_a: assert property (CPU_HALT_OUT && KEYPAD_IRQ_IN |-> ##[1:3] !CPU_HALT_OUT)
    else $error("keypad did not wake");
  wdt_run_a: assert property (!$past(RESET_IN) |-> WATCHDOG_RUN_OUT)
    else $error("watchdog stopped");
  rc_gate_a: assert property (RC_OSCILLATOR_ENABLE_OUT && !OSCILLATOR_ENABLE_OUT
    |-> SYSTEM_TIMER_RUN_OUT)
    else $error("rc oscillator on without timer");
endmodule
bind power_mode_and_reset_control power_reset_props u_props (.*);

// file: tb/reset_sources_model.sv
module reset_sources_model (
  input wire logic clk_in,
  output logic pin_n_out,
  output logic bo_out,
  output logic wdt_out,
  output logic uart_out,
  output logic irq_out,
  output logic wake_out,
  output logic key_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // act[0] pulls the shared pin low; it starts released so power-up can end
  logic [6:0] act = 7'h00;
  assign pin_n_out = !act[0];
  assign {key_out, wake_out, irq_out, uart_out, wdt_out, bo_out} = act[6:1];
  task hold(input int s, input logic v);
    @(posedge clk_in);
    act[s] <= v;
  endtask
  task pulse(input int s, input int n);
    hold(s, 1'b1);
    repeat (n) @(posedge clk_in);
    act[s] <= 1'b0;
  endtask
endmodule

// file: tb/power_mode_and_reset_control_tb_top.sv
module power_mode_and_reset_control_tb_top
  import power_reset_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst = 1'b1;
  logic rd_r = 1'b0;
  logic wr_r = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq, pin, bo, wdt, uart, irq, wake, key, sys_rst, cpu_en, per_en, halt;
  logic osc, rc, bo_en, bo_irq, cmp_en, wdt_run, tmr_run, pin_dig;
  int error_cnt = 0;
  int tests_run = 0;
  int vals[3] = '{0, 3, 255};
  int pers[3] = '{1, 6, 510};
  power_mode_and_reset_control DUT (.CLK_IN(clk), .RESET_IN(rst), .ADDRESS_IN(addr),
    .READ_IN(rd_r), .WRITE_IN(wr_r), .BYTEENABLE_IN(be), .WRITEDATA_IN(wdata),
    .READDATA_OUT(rdata), .WAITREQUEST_OUT(waitreq), .SHARED_RESET_INPUT_PIN_IN(pin),
    .BROWNOUT_DETECT_IN(bo), .WATCHDOG_RESET_IN(wdt), .UART_BREAK_RESET_IN(uart),
    .IRQ_PENDING_IN(irq), .WAKEUP_IRQ_IN(wake), .KEYPAD_IRQ_IN(key),
    .SYSTEM_RESET_OUT(sys_rst), .CPU_CLOCK_EN_OUT(cpu_en), .PERIPH_CLOCK_EN_OUT(per_en),
    .CPU_HALT_OUT(halt), .OSCILLATOR_ENABLE_OUT(osc), .RC_OSCILLATOR_ENABLE_OUT(rc),
    .BROWNOUT_DETECT_ENABLE_OUT(bo_en), .BROWNOUT_IRQ_OUT(bo_irq),
    .COMPARATOR_ENABLE_OUT(cmp_en), .WATCHDOG_RUN_OUT(wdt_run),
    .SYSTEM_TIMER_RUN_OUT(tmr_run), .PIN_DIGITAL_OUT(pin_dig));
  reset_sources_model src (.clk_in(clk), .pin_n_out(pin), .bo_out(bo), .wdt_out(wdt),
    .uart_out(uart), .irq_out(irq), .wake_out(wake), .key_out(key));
  ////////////////////////////////////////////////////////////////////////////
  task results;
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // request held until waitrequest is sampled low; only the watchdog ends a hang
  task acc(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] b,
           output logic [31:0] q);
    @(posedge clk);
    {rd_r, wr_r, addr, be, wdata} <= {!w, w, a, b, 24'h0, d};
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, 4'hF, q);
  endtask
  task rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, 4'hF, q);
    chk(q, e);
  endtask
  task wrst;
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while (sys_rst !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 400), 32'h1);
    repeat (3) @(posedge clk);
  endtask
  // first loop pass only aligns to a pulse, second measures a full period
  task per(input int e);
    int n;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (cpu_en !== 1'b1 && n < 600);
    end
    chk(n, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial begin
    logic [31:0] q;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wrst();
    rd(ADDR_POWER_CONTROL, 32'h14);
    rd(ADDR_RESET_SOURCE, 32'h06);
    rd(ADDR_USER_CONFIG, 32'h0);
    rd(5'h18, 32'h0);
    wr(ADDR_RESET_SOURCE, 8'hFB);
    rd(ADDR_RESET_SOURCE, 32'h02);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CLOCK_DIVIDER, 8'(vals[i]));
      per(pers[i]);
    end
    wr(ADDR_TIMER_CONTROL, 8'h01);
    wr(ADDR_USER_CONFIG, 8'h01);
    acc(1'b1, ADDR_USER_CONFIG, 8'h00, 4'h0, q);
    rd(ADDR_USER_CONFIG, 32'h1);
    src.pulse(2, 3);
    wrst();
    rd(ADDR_RESET_SOURCE, 32'h0A);
    rd(ADDR_CLOCK_DIVIDER, 32'h0);
    rd(ADDR_USER_CONFIG, 32'h1);
    rd(ADDR_TIMER_CONTROL, 32'h1);
    wr(ADDR_POWER_CONTROL, 8'h94);
    wrst();
    rd(ADDR_RESET_SOURCE, 32'h1A);
    src.pulse(3, 3);
    wrst();
    rd(ADDR_RESET_SOURCE, 32'h3A);
    src.pulse(0, 10);
    wrst();
    rd(ADDR_RESET_SOURCE, 32'h3B);
    src.pulse(1, 10);
    wrst();
    rd(ADDR_RESET_SOURCE, 32'h3F);
    wr(ADDR_RESET_SOURCE, 8'h00);
    rd(ADDR_RESET_SOURCE, 32'h0);
    wr(ADDR_POWER_CONTROL, 8'h1C);
    src.hold(1, 1'b1);
    repeat (5) @(posedge clk);
    chk({bo_irq, sys_rst}, 2'b10);
    src.hold(1, 1'b0);
    wr(ADDR_USER_CONFIG, 8'h00);
    src.hold(0, 1'b1);
    repeat (5) @(posedge clk);
    chk({pin_dig, sys_rst}, 2'b00);
    src.hold(0, 1'b0);
    wr(ADDR_POWER_CONTROL, 8'h15);
    repeat (2) @(posedge clk);
    chk({halt, osc, per_en}, 3'b111);
    src.pulse(4, 1);
    repeat (3) @(posedge clk);
    chk(halt, 1'b0);
    wr(ADDR_POWER_CONTROL, 8'h16);
    src.pulse(4, 2);
    repeat (3) @(posedge clk);
    chk({osc, halt}, 2'b01);
    chk({wdt_run, bo_en, cmp_en, tmr_run}, 4'hF);
    rd(ADDR_STATUS, 32'h06);
    src.pulse(5, 1);
    repeat (3) @(posedge clk);
    chk(osc, 1'b1);
    wr(ADDR_POWER_CONTROL, 8'h17);
    repeat (3) @(posedge clk);
    chk({bo_en, cmp_en, osc}, 3'b000);
    src.pulse(6, 1);
    repeat (3) @(posedge clk);
    chk(halt, 1'b0);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_POWER_CONTROL, 8'h36);
    repeat (3) @(posedge clk);
    chk(rc, 1'b0);
    wr(ADDR_TIMER_CONTROL, 8'h01);
    repeat (3) @(posedge clk);
    chk(rc, 1'b1);
    src.pulse(5, 1);
    repeat (3) @(posedge clk);
    // second power-on with the pin held low: pin acts as reset although enable is 0
    src.hold(0, 1'b1);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (80) @(posedge clk);
    chk({sys_rst, pin_dig}, 2'b11);
    src.hold(0, 1'b0);
    wrst();
    rd(ADDR_RESET_SOURCE, 32'h06);
    rd(ADDR_TIMER_CONTROL, 32'h0);
    rd(ADDR_USER_CONFIG, 32'h0);
    results();
  end
endmodule
